//--- common/srps_pkg.sv
// srps_pkg: constants and state type for the card reset and power-down sequencer
// assumes a 100 MHz system clock; card cycle counts are in card clock periods
package srps_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CARD_CLK_NS   = 250;
	localparam int CARD_HALF_CYC = CARD_CLK_NS / (2 * CLK_PERIOD_NS);
	localparam logic [8:0]  RATE_STD     = 9'h174;
	localparam logic [8:0]  RATE_FAST    = 9'h010;
	localparam logic [15:0] RX_HIGH_CYC  = 16'h00c8;
	localparam logic [15:0] ATR_MIN_CYC  = 16'h0190;
	localparam logic [15:0] ATR_MAX_CYC  = 16'h9c40;
	localparam logic [15:0] RST_LOW_CYC  = 16'h9c40;
	localparam logic [15:0] RST_HIGH_CYC = 16'h9c40;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_POWER,
		ST_INT_WAIT,
		ST_LOW_HOLD,
		ST_HIGH_WAIT,
		ST_ACTIVE,
		ST_PD_RST,
		ST_PD_CLK,
		ST_PD_TX
	} srps_state_t;
endpackage

//--- common/srps_clk_if.sv
// srps_clk_if: card clock control and timing strobes between sequencer and clock generator
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface srps_clk_if;
	logic enable;
	logic rate16;
	logic card_clk;
	logic card_tick;
	logic bit_tick;

	modport gen (input enable, input rate16, output card_clk, output card_tick, output bit_tick);
	modport user (output enable, output rate16, input card_clk, input card_tick, input bit_tick);
endinterface

//--- rtl/srps_clkgen.sv
// srps_clkgen: divides the system clock into the card clock and the bit-rate strobe
// assumes enable comes from logic on the same clock
`timescale 1ns/1ps
module srps_clkgen
	import srps_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	srps_clk_if.gen   cif
);
	logic [7:0] half_cnt;
	logic [8:0] bit_cnt;
	wire        half_done = (half_cnt == 8'(CARD_HALF_CYC - 1));
	wire        rise      = half_done & ~cif.card_clk;
	wire  [8:0] ratio     = cif.rate16 ? RATE_FAST : RATE_STD;
	wire        bit_done  = (bit_cnt == ratio - 9'h001);

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			half_cnt      <= 8'h00;
			cif.card_clk  <= 1'b0;
			cif.card_tick <= 1'b0;
		end
		else
		begin
			half_cnt      <= (!cif.enable || half_done) ? 8'h00 : half_cnt + 8'h01;
			cif.card_clk  <= cif.enable & (cif.card_clk ^ half_done);
			cif.card_tick <= cif.enable & rise;
		end
	end

	// data rate is 372 or 16 card clocks per bit
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bit_cnt      <= 9'h000;
			cif.bit_tick <= 1'b0;
		end
		else
		begin
			bit_cnt      <= (!cif.enable || (cif.card_tick && bit_done)) ? 9'h000 : bit_cnt + 9'(cif.card_tick);
			cif.bit_tick <= cif.card_tick & bit_done;
		end
	end

	a_bit_rate: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(cif.card_tick && bit_done && cif.enable) |=> cif.bit_tick && $past(bit_cnt) == $past(ratio - 9'h001))
		else $error("bit strobe off the card clock ratio");
	a_clk_stop: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!cif.enable |=> !cif.card_clk)
		else $error("card clock runs while disabled");
endmodule

//--- rtl/srps_seq.sv
// srps_seq: cold reset and ordered power-down of one smart card port
// assumes card pins, presence detect and slow reference clock are asynchronous to CLOCK_I
`timescale 1ns/1ps
module srps_seq
	import srps_pkg::*;
#(
	parameter bit          SHARED_LINE = 1'b0,
	parameter logic [15:0] RX_HIGH     = RX_HIGH_CYC,
	parameter logic [15:0] ATR_MIN     = ATR_MIN_CYC,
	parameter logic [15:0] ATR_MAX     = ATR_MAX_CYC,
	parameter logic [15:0] RST_LOW     = RST_LOW_CYC,
	parameter logic [15:0] RST_HIGH    = RST_HIGH_CYC
)
(
	input  wire logic CLOCK_I,
	input  wire logic NRST_I,
	input  wire logic START_I,
	input  wire logic PWRDN_REQ_I,
	input  wire logic CARD_TYPE_I,
	input  wire logic RATE16_I,
	input  wire logic TX_DATA_I,
	input  wire logic CARD_PRESENCE_DETECT_I,
	input  wire logic SLOW_REFERENCE_CLOCK_I,
	input  wire logic RX_I,
	input  wire logic SHARED_TX_RX_LINE_I,
	output logic      CARD_CLOCK_PIN_O,
	output logic      CARD_RST_O,
	output logic      TX_O,
	output logic      SHARED_TX_RX_LINE_O,
	output logic      SHARED_TX_RX_LINE_OE_O,
	output logic      VEN_O,
	output logic      BIT_TICK_O,
	output logic      RX_DATA_O,
	output logic      READY_O,
	output logic      RESET_FAIL_O
);
	srps_clk_if  cif ();
	srps_state_t state;
	srps_state_t next_state;
	logic [15:0] cnt;
	logic [2:0]  sync1;
	logic [2:0]  sync2;
	logic [2:0]  sync3;
	logic        rx_high;
	logic        resp_seen;
	logic        clk_en;
	logic        tx_gate;

	srps_clkgen u_clkgen (
		.clk_i  (CLOCK_I),
		.nrst_i (NRST_I),
		.cif    (cif)
	);

	// pins: [0] presence, [1] receive, [2] slow reference
	wire       rx_pin = SHARED_LINE ? SHARED_TX_RX_LINE_I : RX_I;
	wire [2:0] pins   = {SLOW_REFERENCE_CLOCK_I, rx_pin, CARD_PRESENCE_DETECT_I};

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			sync3 <= 3'h7;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	wire removal   = ~sync2[0] & sync3[0];
	wire rx_fall   = ~sync2[1] & sync3[1] & rx_high;
	wire slow_tick = sync2[2] & ~sync3[2];
	wire tick      = cif.card_tick;
	wire powered   = (state != ST_IDLE) && (state != ST_PD_RST) && (state != ST_PD_CLK) && (state != ST_PD_TX);
	wire pd_trig   = powered && (removal || PWRDN_REQ_I);
	wire rx_check  = tick && (cnt == RX_HIGH - 16'h0001);
	wire rx_bad    = rx_check && !sync2[1];
	wire timing    = (state == ST_INT_WAIT) || (state == ST_LOW_HOLD) || (state == ST_HIGH_WAIT);

	// failure cases per state
	wire int_fail  = rx_bad || (rx_fall && cnt < ATR_MIN) || (tick && cnt == ATR_MAX - 16'h0001);
	wire low_fail  = rx_bad || rx_fall;
	wire high_fail = (rx_fall && (cnt < ATR_MIN || cnt >= ATR_MAX))
		|| (tick && cnt == RST_HIGH - 16'h0001 && !resp_seen);
	wire fail      = (state == ST_INT_WAIT && int_fail) || (state == ST_LOW_HOLD && low_fail)
		|| (state == ST_HIGH_WAIT && high_fail);

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (START_I && sync2[0])
					next_state = ST_POWER;
			ST_POWER:
				next_state = CARD_TYPE_I ? ST_LOW_HOLD : ST_INT_WAIT;
			ST_INT_WAIT:
				if (rx_fall && cnt >= ATR_MIN)
					next_state = ST_ACTIVE;
			ST_LOW_HOLD:
				if (tick && cnt == RST_LOW - 16'h0001)
					next_state = ST_HIGH_WAIT;
			ST_HIGH_WAIT:
				if (tick && cnt == RST_HIGH - 16'h0001 && resp_seen)
					next_state = ST_ACTIVE;
			ST_PD_RST:
				if (slow_tick)
					next_state = ST_PD_CLK;
			ST_PD_CLK:
				if (slow_tick)
					next_state = ST_PD_TX;
			ST_PD_TX:
				if (slow_tick)
					next_state = ST_IDLE;
			ST_ACTIVE:
				next_state = ST_ACTIVE;
			default:
				next_state = ST_IDLE;
		endcase
		if (pd_trig || fail)
			next_state = ST_PD_RST;
	end

	wire next_ven   = (next_state != ST_IDLE);
	wire next_clk   = next_ven && (next_state != ST_POWER) && (next_state != ST_PD_CLK) && (next_state != ST_PD_TX);
	wire next_rst   = (next_state == ST_HIGH_WAIT) || (next_state == ST_ACTIVE);
	wire next_gate  = next_ven && (next_state != ST_POWER) && (next_state != ST_PD_TX);
	wire next_txpin = tx_gate && TX_DATA_I;

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			state     <= ST_IDLE;
			cnt       <= 16'h0000;
			rx_high   <= 1'b0;
			resp_seen <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			cnt       <= (next_state != state) ? 16'h0000 : cnt + 16'(tick && timing);
			rx_high   <= (state == ST_POWER) ? 1'b0 : (rx_high || (rx_check && sync2[1]));
			resp_seen <= (state != ST_HIGH_WAIT) ? 1'b0 : (resp_seen || rx_fall);
		end
	end

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			clk_en                 <= 1'b0;
			tx_gate                <= 1'b0;
			VEN_O                  <= 1'b0;
			CARD_RST_O             <= 1'b0;
			TX_O                   <= 1'b0;
			SHARED_TX_RX_LINE_O    <= 1'b0;
			SHARED_TX_RX_LINE_OE_O <= 1'b0;
			CARD_CLOCK_PIN_O       <= 1'b0;
			BIT_TICK_O             <= 1'b0;
			RX_DATA_O              <= 1'b1;
			READY_O                <= 1'b0;
			RESET_FAIL_O           <= 1'b0;
		end
		else
		begin
			clk_en                 <= next_clk;
			tx_gate                <= next_gate;
			VEN_O                  <= next_ven;
			CARD_RST_O             <= next_rst;
			TX_O                   <= next_txpin;
			SHARED_TX_RX_LINE_O    <= 1'b0;
			SHARED_TX_RX_LINE_OE_O <= SHARED_LINE && VEN_O && !next_txpin;
			CARD_CLOCK_PIN_O       <= cif.card_clk;
			BIT_TICK_O             <= cif.bit_tick;
			RX_DATA_O              <= sync2[1];
			READY_O                <= (next_state == ST_ACTIVE);
			RESET_FAIL_O           <= fail || (RESET_FAIL_O && !(state == ST_IDLE && next_state == ST_POWER));
		end
	end

	assign cif.enable = clk_en;
	assign cif.rate16 = RATE16_I;

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);

	a_clk_first: assert property ((state == ST_POWER && next_state != ST_PD_RST) |=> clk_en && !CARD_RST_O)
		else $error("card clock not started at sequence start");
	a_rx_window: assert property ((state == ST_INT_WAIT && rx_fall && cnt < ATR_MIN) |=> state == ST_PD_RST)
		else $error("early answer not rejected");
	a_low_hold: assert property ((state == ST_LOW_HOLD && cnt < RST_LOW - 16'h0001) |=> !CARD_RST_O)
		else $error("reset released before low interval");
	a_high_hold: assert property ((state == ST_HIGH_WAIT && !pd_trig && !fail) |=> CARD_RST_O)
		else $error("reset dropped during high interval");
	a_resp_late: assert property ((state == ST_HIGH_WAIT && rx_fall && cnt >= ATR_MAX) |=> state == ST_PD_RST)
		else $error("late answer not rejected");
	a_pd_start: assert property (pd_trig |=> state == ST_PD_RST ##1 !CARD_RST_O)
		else $error("power-down not started");
	a_pd_order: assert property ($fell(VEN_O) |-> !CARD_RST_O && !clk_en && !TX_O)
		else $error("supply dropped before other pins");
	a_rst_first: assert property ($fell(clk_en) |-> !CARD_RST_O)
		else $error("clock stopped before reset low");
	a_pd_step: assert property ((state == ST_PD_CLK && !slow_tick && !pd_trig) |=> state == ST_PD_CLK)
		else $error("power-down step left early");
	a_sync_pd: assert property ($fell(sync2[0]) |-> $past(CARD_PRESENCE_DETECT_I, 2) == 1'b0)
		else $error("presence detect not synchronised");
endmodule

//--- tb/srps_card_model.sv
// srps_card_model: behavioural card answering a cold reset on its receive line
// assumes card clock, reset and supply come from the sequencer under test
`timescale 1ns/1ps
module srps_card_model (
	input  wire logic card_clk_i,
	input  wire logic rst_i,
	input  wire logic ven_i,
	input  wire logic type_i,
	input  wire logic [31:0] ans_at_i,
	output logic      rx_o
);
	logic [15:0] cnt;
	logic        rst_q;
	// card clocks since clock start, or since reset rise for active-low cards
	always @(posedge card_clk_i or negedge ven_i)
	begin
		if (!ven_i)
		begin
			cnt <= 16'h0000;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_q <= rst_i;
			cnt <= (type_i && rst_i && !rst_q) ? 16'h0000 : cnt + 16'h0001;
		end
	end
	// line pulled high except during the four-clock answer
	assign rx_o = !(ven_i && cnt >= ans_at_i && cnt < ans_at_i + 4 && (!type_i || rst_q));
endmodule

//--- tb/srps_seq_tb.sv
// srps_seq_tb: self-checking bench for the card reset and power-down sequencer
// assumes shortened card-clock counts and a 125 ns slow reference clock
`timescale 1ns/1ps
module srps_seq_tb;
	import srps_pkg::*;
	logic CLOCK_I, NRST_I, START_I, PWRDN_REQ_I, CARD_TYPE_I, RATE16_I, TX_DATA_I, PD, SLOW, RX;
	logic CARD_CLOCK_PIN_O, CARD_RST_O, TX_O, VEN_O, BIT_TICK_O, RX_DATA_O, READY_O, RESET_FAIL_O, SH_O, SH_OE;
	int   miscompares, n_checks, ncc, ntk, tk_prev, tk_gap, ans;

	always #5 CLOCK_I = ~CLOCK_I;
	initial
	begin
		SLOW = 0;
		#3;
		forever #62.5 SLOW = ~SLOW;
	end
	always @(posedge CARD_CLOCK_PIN_O) ncc++;
	always @(posedge CLOCK_I)
		if (BIT_TICK_O === 1'b1)
		begin
			tk_gap = ncc - tk_prev;
			tk_prev = ncc;
			ntk++;
		end

	srps_seq #(.RX_HIGH(16'h0004), .ATR_MIN(16'h0008), .ATR_MAX(16'h0028), .RST_LOW(16'h0028),
		.RST_HIGH(16'h0028)) dut (
		.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .START_I(START_I), .PWRDN_REQ_I(PWRDN_REQ_I),
		.CARD_TYPE_I(CARD_TYPE_I), .RATE16_I(RATE16_I), .TX_DATA_I(TX_DATA_I),
		.CARD_PRESENCE_DETECT_I(PD), .SLOW_REFERENCE_CLOCK_I(SLOW), .RX_I(RX), .SHARED_TX_RX_LINE_I(RX),
		.CARD_CLOCK_PIN_O(CARD_CLOCK_PIN_O), .CARD_RST_O(CARD_RST_O), .TX_O(TX_O),
		.SHARED_TX_RX_LINE_O(SH_O), .SHARED_TX_RX_LINE_OE_O(SH_OE), .VEN_O(VEN_O), .BIT_TICK_O(BIT_TICK_O),
		.RX_DATA_O(RX_DATA_O), .READY_O(READY_O), .RESET_FAIL_O(RESET_FAIL_O));
	srps_card_model card (.card_clk_i(CARD_CLOCK_PIN_O), .rst_i(CARD_RST_O), .ven_i(VEN_O),
		.type_i(CARD_TYPE_I), .ans_at_i(ans), .rx_o(RX));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task start(input logic typ, input int a);
		ans = a;
		@(posedge CLOCK_I);
		CARD_TYPE_I <= typ;
		START_I <= 1'b1;
		@(posedge CLOCK_I);
		START_I <= 1'b0;
	endtask
	task wait_end(input int lim);
		for (int i = 0; i < lim; i++)
		begin
			@(posedge CLOCK_I);
			#1;
			if (READY_O === 1'b1 || RESET_FAIL_O === 1'b1)
				break;
		end
	endtask
	task wait_ticks(input int k, input int lim);
		int n0;
		n0 = ntk;
		for (int i = 0; i < lim && ntk < n0 + k; i++)
		begin
			@(posedge CLOCK_I);
			#1;
		end
	endtask
	// watches the four pins fall after a trigger
	task pd_check;
		int tr, tc, tt, tv;
		tr = -1;
		tc = 0;
		tt = -1;
		tv = -1;
		for (int i = 0; i < 400 && tv < 0; i++)
		begin
			@(posedge CLOCK_I);
			#1;
			if (tr < 0 && CARD_RST_O === 1'b0) tr = i;
			if (CARD_CLOCK_PIN_O !== 1'b0) tc = i + 1;
			if (tt < 0 && TX_O === 1'b0) tt = i;
			if (VEN_O === 1'b0) tv = i;
		end
		chk(tr >= 0 && tr < tc && tc <= tt && tt < tv, 1);
		chk(tv - tr >= 20 && tv - tr <= 45, 1);
		chk(READY_O, 0);
		repeat (5) @(posedge CLOCK_I);
	endtask
	task t_internal;
		int c0;
		c0 = ncc;
		start(1'b0, 20);
		for (int i = 0; i < 200 && ncc == c0; i++)
		begin
			@(posedge CLOCK_I);
			#1;
		end
		chk({VEN_O, CARD_RST_O}, 2'b10);
		wait_end(3000);
		chk(READY_O, 1);
		chk(RX_DATA_O, 0);
		chk(ncc - c0 >= 20, 1);
		chk(CARD_RST_O, 1);
		chk({SH_O, SH_OE}, 2'b00);
		@(posedge CLOCK_I);
		PWRDN_REQ_I <= 1'b1;
		@(posedge CLOCK_I);
		PWRDN_REQ_I <= 1'b0;
		pd_check();
	endtask
	task t_early;
		start(1'b0, 5);
		wait_end(3000);
		chk(RESET_FAIL_O, 1);
		chk(READY_O, 0);
		for (int i = 0; i < 400 && VEN_O !== 1'b0; i++)
		begin
			@(posedge CLOCK_I);
			#1;
		end
		chk(VEN_O, 0);
		repeat (5) @(posedge CLOCK_I);
	endtask
	task t_active;
		int c0, c1;
		c0 = ncc;
		start(1'b1, 20);
		for (int i = 0; i < 3000 && CARD_RST_O !== 1'b1; i++)
		begin
			@(posedge CLOCK_I);
			#1;
		end
		chk(ncc - c0 >= 40 && ncc - c0 <= 42, 1);
		c1 = ncc;
		wait_end(3000);
		chk(READY_O, 1);
		chk(RESET_FAIL_O, 0);
		chk(ncc - c1 >= 39, 1);
		chk(CARD_RST_O, 1);
		@(posedge CLOCK_I);
		PD <= 1'b0;
		pd_check();
		PD <= 1'b1;
		repeat (5) @(posedge CLOCK_I);
	endtask
	task t_rate;
		@(posedge CLOCK_I);
		RATE16_I <= 1'b1;
		start(1'b0, 20);
		wait_end(3000);
		wait_ticks(3, 3000);
		chk(tk_gap, 16);
		RATE16_I <= 1'b0;
		wait_ticks(3, 40000);
		chk(tk_gap, 372);
		PWRDN_REQ_I <= 1'b1;
		@(posedge CLOCK_I);
		PWRDN_REQ_I <= 1'b0;
		pd_check();
	endtask

	initial
	begin
		CLOCK_I = 0;
		NRST_I = 0;
		START_I = 0;
		PWRDN_REQ_I = 0;
		CARD_TYPE_I = 0;
		RATE16_I = 0;
		TX_DATA_I = 1;
		PD = 1;
		ans = 20;
		repeat (6) @(posedge CLOCK_I);
		NRST_I <= 1'b1;
		repeat (4) @(posedge CLOCK_I);
		t_internal();
		t_early();
		t_active();
		t_rate();
		results();
	end
	initial
	begin
		#1000000;
		miscompares++;
		results();
	end
endmodule
